// file: hdl/uag_txgap_autobaud.sv
// Chosen here: register access over Avalon-MM.
`timescale 1ns/10ps
// What this block does
// - Done flag sets when auto-baud receives letter A or a; zero before.
// - Writing one to the clear bit clears the done flag.
// - Writing zero to the clear bit does nothing; it reads zero.
// - Auto-baud alignment runs only while the align enable bit is one.
// - Programmable 8-bit gap, in baud cycles, between FIFO-to-shifter moves.
// - Holding buffer loads only after the shifter sent its last bit.
// - Suspend field 00: stop immediately on emulation suspend.
// - Suspend field 10: finish current frame, then halt.
// - Run-on bit one: ignore emulation suspend entirely.
// - Reserved suspend register bits read zero; writes are ignored.
module uag_txgap_autobaud import uag_pkg::*; #(
    parameter int DIV_W = 16,
    parameter logic [15:0] BAUD_DIV = 16'(UAG_CLK_HZ / UAG_BAUD_DEF)
) (
    input wire logic clk_sys, // System clock, 10 MHz.
    input wire logic rst, // Asynchronous reset, active high.
    input wire logic [15:0] avs_address, // Avalon word address.
    input wire logic avs_read, // Avalon read request.
    input wire logic avs_write, // Avalon write request.
    input wire logic [31:0] avs_writedata, // Avalon write data.
    output logic [31:0] avs_readdata, // Avalon read data.
    output logic avs_waitrequest, // Avalon wait request.
    input wire logic txf_valid, // Transmit FIFO has a word.
    input wire logic [7:0] txf_data, // Transmit FIFO head word.
    output logic txf_ready, // Word taken from the transmit FIFO.
    input wire logic rx_pin, // Serial receive line.
    output logic tx_pin, // Serial transmit line.
    input wire logic emu_suspend, // Emulation suspend request.
    output logic irq // Level interrupt.
);
    logic acc_q;
    logic wr_en;
    logic [31:0] rd_mux;
    logic [31:0] readdata_q;
    logic done_q;
    logic align_q;
    logic [UAG_GAP_W-1:0] gap_q;
    logic grace_q;
    logic runon_q;
    logic [UAG_EV_W-1:0] sts_q;
    logic [UAG_EV_W-1:0] msk_q;
    logic [UAG_EV_W-1:0] ev;
    logic rx_m_q, rx_s_q, su_m_q, su_s_q;
    logic susp_req, halt_imm;
    logic [DIV_W-1:0] baud_div_q;
    logic [DIV_W-1:0] baud_cnt_q;
    logic tick;
    logic [7:0] rx_byte;
    logic rx_valid;
    logic [DIV_W-1:0] meas_period;
    logic rx_busy;
    logic rx_run;
    logic set_done;
    logic clr_done;
    logic tx_go;
    logic [UAG_GAP_W-1:0] gap_cnt_q;
    logic [7:0] hold_q;
    logic hold_full_q;
    logic [UAG_FRAME_BITS-1:0] shift_q;
    logic [3:0] tx_bits_q;
    logic tx_busy_q;
    logic tx_done_q;
    logic tx_q;

    // One wait cycle on every access gives read data a flop to come from.
    assign avs_waitrequest = (avs_read | avs_write) & ~acc_q;
    assign wr_en = avs_write & ~avs_waitrequest;
    assign avs_readdata = readdata_q;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            acc_q <= 1'b0;
        end else begin
            acc_q <= (avs_read | avs_write) & ~acc_q;
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (avs_address)
            UAG_IDX_FGAP: begin
                rd_mux[UAG_F_DONE] = done_q;
                rd_mux[UAG_F_CLR] = 1'b0;
                rd_mux[UAG_F_ALIGN] = align_q;
                rd_mux[UAG_F_GAP_LSB +: UAG_GAP_W] = gap_q;
            end
            UAG_IDX_SUSP: begin
                rd_mux[UAG_F_GRACE] = grace_q;
                rd_mux[UAG_F_RUNON] = runon_q;
            end
            UAG_IDX_ISTS: rd_mux[UAG_EV_W-1:0] = sts_q;
            UAG_IDX_IMSK: rd_mux[UAG_EV_W-1:0] = msk_q;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            readdata_q <= 32'h0000_0000;
        end else if (avs_read & ~acc_q) begin
            readdata_q <= rd_mux;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            align_q <= UAG_ALIGN_RST;
            gap_q <= UAG_GAP_RST;
        end else if (wr_en && avs_address == UAG_IDX_FGAP) begin
            align_q <= avs_writedata[UAG_F_ALIGN];
            gap_q <= avs_writedata[UAG_F_GAP_LSB +: UAG_GAP_W];
        end
    end

    // Only the two mode bits are stored, so reserved bits can never hold a value.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            grace_q <= UAG_GRACE_RST;
            runon_q <= UAG_RUNON_RST;
        end else if (wr_en && avs_address == UAG_IDX_SUSP) begin
            grace_q <= avs_writedata[UAG_F_GRACE];
            runon_q <= avs_writedata[UAG_F_RUNON];
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            msk_q <= UAG_IMSK_RST;
        end else if (wr_en && avs_address == UAG_IDX_IMSK) begin
            msk_q <= avs_writedata[UAG_EV_W-1:0];
        end
    end

    always_comb begin
        ev = '0;
        ev[UAG_EV_DONE] = set_done;
        ev[UAG_EV_TXD] = tx_done_q;
    end

    // A new event beats a write-one-to-clear in the same cycle.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sts_q <= '0;
        end else if (wr_en && avs_address == UAG_IDX_ISTS) begin
            sts_q <= ev | (sts_q & ~avs_writedata[UAG_EV_W-1:0]);
        end else begin
            sts_q <= ev | sts_q;
        end
    end

    assign irq = |(sts_q & msk_q);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rx_m_q <= 1'b1;
            rx_s_q <= 1'b1;
            su_m_q <= 1'b0;
            su_s_q <= 1'b0;
        end else begin
            rx_m_q <= rx_pin;
            rx_s_q <= rx_m_q;
            su_m_q <= emu_suspend;
            su_s_q <= su_m_q;
        end
    end

    assign susp_req = su_s_q & ~runon_q;
    assign halt_imm = susp_req & ~grace_q;
    // Graceful mode lets a receive in progress run to its stop bit.
    assign rx_run = ~(susp_req & (~grace_q | ~rx_busy));

    uag_rx #(
        .DIV_W(DIV_W)
    ) u_rx (
        .clk_sys(clk_sys),
        .rst(rst),
        .run(rx_run),
        .rx_s(rx_s_q),
        .measure(align_q & ~done_q),
        .bit_period(baud_div_q),
        .rx_byte_q(rx_byte),
        .rx_valid_q(rx_valid),
        .meas_period_q(meas_period),
        .rx_busy(rx_busy)
    );

    assign set_done = rx_valid & align_q & ~done_q & (rx_byte == UAG_CHAR_UA || rx_byte == UAG_CHAR_LA);
    assign clr_done = wr_en && avs_address == UAG_IDX_FGAP && avs_writedata[UAG_F_CLR];

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            done_q <= 1'b0;
        end else begin
            done_q <= set_done | (done_q & ~clr_done);
        end
    end

    // The measured start bit replaces the divisor only on a good letter.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            baud_div_q <= DIV_W'(BAUD_DIV);
        end else if (set_done) begin
            baud_div_q <= meas_period;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            baud_cnt_q <= '0;
        end else if (!halt_imm) begin
            if (baud_cnt_q == '0) begin
                baud_cnt_q <= baud_div_q - 1'b1;
            end else begin
                baud_cnt_q <= baud_cnt_q - 1'b1;
            end
        end
    end

    assign tick = (baud_cnt_q == '0) & ~halt_imm;

    assign tx_go = txf_valid & ~tx_busy_q & (gap_cnt_q == '0) & ~susp_req;
    assign txf_ready = tx_go;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            gap_cnt_q <= '0;
        end else if (tx_go) begin
            gap_cnt_q <= gap_q;
        end else if (tick && gap_cnt_q != '0) begin
            gap_cnt_q <= gap_cnt_q - 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hold_q <= 8'h00;
            hold_full_q <= 1'b0;
        end else if (tx_go) begin
            hold_q <= txf_data;
            hold_full_q <= 1'b1;
        end else if (hold_full_q && !halt_imm) begin
            hold_full_q <= 1'b0;
        end
    end

    // Busy covers holding and shifting, so the holding buffer never acts as an extra level.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            shift_q <= '1;
            tx_bits_q <= 4'h0;
            tx_busy_q <= 1'b0;
            tx_done_q <= 1'b0;
            tx_q <= 1'b1;
        end else begin
            tx_done_q <= 1'b0;
            if (tx_go) begin
                tx_busy_q <= 1'b1;
            end else if (hold_full_q && !halt_imm) begin
                shift_q <= {1'b1, hold_q, 1'b0};
                tx_bits_q <= 4'(UAG_FRAME_BITS + 1);
            end else if (tick && tx_bits_q > 4'h1) begin
                tx_q <= shift_q[0];
                shift_q <= {1'b1, shift_q[UAG_FRAME_BITS-1:1]};
                tx_bits_q <= tx_bits_q - 1'b1;
            end else if (tick && tx_bits_q == 4'h1) begin
                tx_bits_q <= 4'h0;
                tx_busy_q <= 1'b0;
                tx_done_q <= 1'b1;
            end
        end
    end

    assign tx_pin = tx_q;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    chk_done_set: assert property (set_done |=> done_q)
        else $error("done flag did not set after a good letter");
    chk_done_clear: assert property (clr_done && !set_done |=> !done_q)
        else $error("done flag survived a clear");
    chk_clear_reads0: assert property (avs_read && !avs_waitrequest && avs_address == UAG_IDX_FGAP
        |-> !avs_readdata[UAG_F_CLR])
        else $error("clear bit read back as one");
    chk_zero_write_keep: assert property (wr_en && avs_address == UAG_IDX_FGAP && !avs_writedata[UAG_F_CLR]
        && done_q |=> done_q)
        else $error("writing zero to the clear bit lost the flag");
    chk_align_off_hold: assert property (!align_q |=> $stable(baud_div_q) && !$rose(done_q))
        else $error("alignment acted while disabled");
    chk_gap_block: assert property (tx_go |=> (!txf_ready)[*2])
        else $error("back to back transfers without a gap");
    chk_gap_load: assert property (tx_go |=> gap_cnt_q == $past(gap_q))
        else $error("gap counter did not take the programmed delay");
    chk_hold_after_last: assert property (txf_ready |-> !tx_busy_q && tx_bits_q == 4'h0)
        else $error("holding buffer loaded while shifting");
    chk_immediate_stop: assert property (halt_imm |=> $stable(shift_q) && $stable(gap_cnt_q))
        else $error("transmitter moved during immediate stop");
    chk_graceful_stop: assert property (susp_req && grace_q |-> !txf_ready)
        else $error("new frame started during graceful suspend");
    chk_run_on_free: assert property (runon_q |-> !halt_imm && rx_run)
        else $error("suspend acted with run-on set");
    chk_rsvd_zero: assert property (avs_read && !avs_waitrequest && avs_address == UAG_IDX_SUSP
        |-> avs_readdata[7:5] == 3'h0 && avs_readdata[2:0] == 3'h0)
        else $error("reserved suspend bits read nonzero");

    // The bench only sees the larger of gap and frame time, so the gap counter is checked tick by tick.
    chk_gap_blocks: assert property (gap_cnt_q != '0 |-> !txf_ready)
        else $error("transfer taken while the gap was counting");
    chk_gap_step: assert property (tick && !tx_go && gap_cnt_q != '0
        |=> gap_cnt_q == $past(gap_cnt_q) - 1'b1)
        else $error("gap counter missed a baud tick");
    chk_gap_hold: assert property (!tick && !tx_go |=> $stable(gap_cnt_q))
        else $error("gap counter moved without a baud tick");
    chk_line_idle: assert property (!tx_busy_q |-> tx_pin)
        else $error("line not idle high between frames");

    chk_done_needs_align: assert property ($rose(done_q) |-> $past(align_q))
        else $error("done flag rose with alignment disabled");
    chk_done_event: assert property (set_done |=> sts_q[UAG_EV_DONE])
        else $error("done event missing from the status register");
    // A new event in the same cycle keeps its bit, so the clear is only checked without one.
    chk_ists_clear: assert property (wr_en && avs_address == UAG_IDX_ISTS && !set_done
        && avs_writedata[UAG_EV_DONE] |=> !sts_q[UAG_EV_DONE])
        else $error("status bit survived a write of one");
    chk_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("more than one wait state on a register access");

    // Immediate stop freezes the line; graceful suspend keeps the frame in progress moving.
    chk_halt_freeze: assert property (halt_imm |=> $stable(tx_pin) && $stable(tx_bits_q))
        else $error("line moved during immediate stop");
    chk_graceful_rx: assert property (susp_req && grace_q && rx_busy |-> rx_run)
        else $error("receive frame cut during graceful suspend");
    chk_graceful_tx: assert property (susp_req && grace_q && tx_busy_q && tick
        |=> tx_bits_q != $past(tx_bits_q))
        else $error("transmit frame stalled during graceful suspend");

    cov_autobaud_done: cover property ($rose(done_q));
    cov_tx_transfer: cover property (tx_go ##[1:300] tx_done_q);
    cov_halt_imm: cover property (halt_imm && tx_busy_q);
    cov_irq: cover property ($rose(irq));
    cov_graceful_done: cover property (susp_req && grace_q && tx_done_q);
endmodule

// file: hdl/uag_pkg.sv
package uag_pkg;
    // Word indices of the registers; the byte address is four times the index.
    localparam logic [15:0] UAG_IDX_FGAP = 16'h705C;
    localparam logic [15:0] UAG_IDX_SUSP = 16'h705F;
    localparam logic [15:0] UAG_IDX_ISTS = 16'h7060;
    localparam logic [15:0] UAG_IDX_IMSK = 16'h7061;

    // Field positions of the transfer gap and auto-baud control register.
    localparam int UAG_F_DONE = 15;
    localparam int UAG_F_CLR = 14;
    localparam int UAG_F_ALIGN = 13;
    localparam int UAG_F_GAP_LSB = 0;
    localparam int UAG_GAP_W = 8;

    // Field positions of the suspend control register.
    localparam int UAG_F_GRACE = 4;
    localparam int UAG_F_RUNON = 3;

    // Interrupt status and mask layout.
    localparam int UAG_EV_DONE = 0;
    localparam int UAG_EV_TXD = 1;
    localparam int UAG_EV_W = 2;

    // Reset values.
    localparam logic [UAG_GAP_W-1:0] UAG_GAP_RST = 8'h00;
    localparam logic UAG_ALIGN_RST = 1'h0;
    localparam logic UAG_GRACE_RST = 1'h0;
    localparam logic UAG_RUNON_RST = 1'h0;
    localparam logic [UAG_EV_W-1:0] UAG_IMSK_RST = 2'h0;

    // Characters that complete auto-baud detection.
    localparam logic [7:0] UAG_CHAR_UA = 8'h41;
    localparam logic [7:0] UAG_CHAR_LA = 8'h61;

    // Frame shape: start bit, eight data bits, one stop bit.
    localparam int UAG_DATA_BITS = 8;
    localparam int UAG_FRAME_BITS = 10;

    // Clock rate and the default line rate the divider starts from.
    localparam int UAG_CLK_HZ = 10000000;
    localparam int UAG_BAUD_DEF = 115200;

    typedef enum logic [2:0] {
        UAG_RX_IDLE,
        UAG_RX_MEAS,
        UAG_RX_START,
        UAG_RX_DATA,
        UAG_RX_STOP
    } uag_rx_state_t;
endpackage

// file: hdl/uag_rx.sv
`timescale 1ns/10ps
module uag_rx import uag_pkg::*; #(
    parameter int DIV_W = 16
) (
    input wire logic clk_sys, // System clock.
    input wire logic rst, // Asynchronous reset, active high.
    input wire logic run, // Low freezes the receiver.
    input wire logic rx_s, // Synchronised receive line.
    input wire logic measure, // Take the bit time from the start bit.
    input wire logic [DIV_W-1:0] bit_period, // Bit time in clock cycles.
    output logic [7:0] rx_byte_q, // Last received character.
    output logic rx_valid_q, // One-cycle pulse with a new character.
    output logic [DIV_W-1:0] meas_period_q, // Start bit length last measured.
    output logic rx_busy // A frame is in progress.
);
    uag_rx_state_t state_q;
    logic [DIV_W-1:0] cnt_q;
    logic [2:0] bit_q;
    logic [7:0] shreg_q;
    logic [DIV_W-1:0] per;

    // In measuring mode the start bit of the character itself sets the bit time.
    assign per = measure ? meas_period_q : bit_period;
    assign rx_busy = (state_q != UAG_RX_IDLE);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q <= UAG_RX_IDLE;
            cnt_q <= '0;
            bit_q <= 3'h0;
            shreg_q <= 8'h00;
            rx_byte_q <= 8'h00;
            rx_valid_q <= 1'b0;
            meas_period_q <= '0;
        end else begin
            rx_valid_q <= 1'b0;
            if (run) begin
                unique case (state_q)
                    UAG_RX_IDLE: begin
                        if (!rx_s) begin
                            if (measure) begin
                                cnt_q <= DIV_W'(1);
                                state_q <= UAG_RX_MEAS;
                            end else begin
                                cnt_q <= bit_period >> 1;
                                state_q <= UAG_RX_START;
                            end
                        end
                    end
                    UAG_RX_MEAS: begin
                        // Both letters carry a one in bit 0, so the start bit ends on a rising edge.
                        if (rx_s) begin
                            meas_period_q <= cnt_q;
                            cnt_q <= cnt_q >> 1;
                            bit_q <= 3'h0;
                            state_q <= UAG_RX_DATA;
                        end else if (cnt_q != '1) begin
                            cnt_q <= cnt_q + 1'b1;
                        end
                    end
                    UAG_RX_START: begin
                        if (cnt_q == '0) begin
                            if (!rx_s) begin
                                cnt_q <= bit_period - 1'b1;
                                bit_q <= 3'h0;
                                state_q <= UAG_RX_DATA;
                            end else begin
                                state_q <= UAG_RX_IDLE;
                            end
                        end else begin
                            cnt_q <= cnt_q - 1'b1;
                        end
                    end
                    UAG_RX_DATA: begin
                        if (cnt_q == '0) begin
                            shreg_q <= {rx_s, shreg_q[7:1]};
                            cnt_q <= per - 1'b1;
                            bit_q <= bit_q + 1'b1;
                            if (bit_q == 3'(UAG_DATA_BITS - 1)) begin
                                state_q <= UAG_RX_STOP;
                            end
                        end else begin
                            cnt_q <= cnt_q - 1'b1;
                        end
                    end
                    UAG_RX_STOP: begin
                        if (cnt_q == '0) begin
                            rx_byte_q <= shreg_q;
                            rx_valid_q <= rx_s;
                            state_q <= UAG_RX_IDLE;
                        end else begin
                            cnt_q <= cnt_q - 1'b1;
                        end
                    end
                endcase
            end
        end
    end
endmodule

// file: dv/uag_node.sv
`timescale 1ns/10ps
// Remote serial node: drives the device's receive line and decodes its transmit line.
module uag_node #(
    parameter int BIT = 4
) (
    input wire logic clk_sys, // System clock.
    input wire logic tx_pin, // Line from the device.
    output logic rx_pin // Line into the device.
);
    logic [7:0] got_q[$];
    logic [7:0] b;
    int n_bad;
    // The line idles high between frames, as a pulled-up line would.
    initial begin
        rx_pin = 1'b1;
        n_bad = 0;
    end
    task automatic send(input logic [7:0] c);
        @(posedge clk_sys);
        rx_pin <= 1'b0;
        repeat (BIT) @(posedge clk_sys);
        for (int i = 0; i < 8; i++) begin
            rx_pin <= c[i];
            repeat (BIT) @(posedge clk_sys);
        end
        rx_pin <= 1'b1;
        repeat (2 * BIT) @(posedge clk_sys);
    endtask
    // Bits are taken mid-cell; a low stop bit counts as a broken frame.
    initial begin
        forever begin
            @(negedge tx_pin);
            repeat (BIT / 2) @(posedge clk_sys);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT) @(posedge clk_sys);
                b[i] = tx_pin;
            end
            repeat (BIT) @(posedge clk_sys);
            if (tx_pin !== 1'b1) n_bad++;
            got_q.push_back(b);
        end
    end
endmodule

// file: dv/tb.sv
`timescale 1ns/10ps
module tb;
    import uag_pkg::*;
    logic clk_sys, rst, avs_read, avs_write, avs_waitrequest;
    logic [15:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic txf_valid, txf_ready, rx_pin, tx_pin, emu_suspend, irq, v;
    logic [7:0] txf_data;
    logic [15:0] ra [5] = '{UAG_IDX_FGAP, UAG_IDX_SUSP, UAG_IDX_ISTS, UAG_IDX_IMSK, 16'h7000};
    logic [7:0] ch [4] = '{8'h41, 8'h42, 8'h41, 8'h61};
    logic ab [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
    logic [31:0] al;
    int errors = 0;
    int n_checks = 0;
    int cyc = 0;
    int xt[$];
    uag_txgap_autobaud #(.BAUD_DIV(16'h0004)) uut (.clk_sys(clk_sys), .rst(rst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .txf_valid(txf_valid), .txf_data(txf_data), .txf_ready(txf_ready), .rx_pin(rx_pin),
        .tx_pin(tx_pin), .emu_suspend(emu_suspend), .irq(irq));
    uag_node #(.BIT(4)) node (.clk_sys(clk_sys), .tx_pin(tx_pin), .rx_pin(rx_pin));
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (txf_valid === 1'b1 && txf_ready === 1'b1) xt.push_back(cyc);
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic timed_out(input string what);
        errors++;
        $display("mismatch %s expected answer seen timeout", what);
        wrap_up();
    endtask
    // Waitrequest and read data are sampled at the rising edge that ends the wait; the request drops there.
    task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        for (i = 0; i < 50; i++) begin
            @(posedge clk_sys);
            if (avs_waitrequest === 1'b0) break;
        end
        if (i == 50) timed_out("waitrequest");
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic rchk(input string what, input logic [15:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask
    // A refused word keeps txf_valid high, so the next push simply carries on waiting.
    task automatic push(input logic [7:0] c, input int n, input bit want);
        int i;
        @(posedge clk_sys);
        txf_valid <= 1'b1;
        txf_data <= c;
        for (i = 0; i < n; i++) begin
            @(posedge clk_sys);
            if (txf_ready === 1'b1) break;
        end
        if (want) begin
            if (i == n) timed_out("transfer");
            txf_valid <= 1'b0;
        end else begin
            chk("transfer refused", 32'h1, {31'h0, i == n});
        end
    endtask
    task automatic wait_rx(input int n);
        int i;
        for (i = 0; i < 3000; i++) begin
            if (node.got_q.size() >= n) break;
            @(posedge clk_sys);
        end
        if (i == 3000) timed_out("frame");
    endtask
    task automatic pair(input logic [7:0] a, input logic [7:0] b, input int lo, input int hi);
        int n0;
        n0 = node.got_q.size();
        xt.delete();
        push(a, 2000, 1'b1);
        push(b, 3000, 1'b1);
        wait_rx(n0 + 2);
        chk("transfer spacing in range", 32'h1, {31'h0, xt[1] - xt[0] >= lo && xt[1] - xt[0] <= hi});
        chk("first byte", {24'h0, a}, {24'h0, node.got_q[n0]});
        chk("second byte", {24'h0, b}, {24'h0, node.got_q[n0 + 1]});
    endtask
    initial begin
        rst = 1'b1;
        avs_address = 16'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        txf_valid = 1'b0;
        txf_data = 8'h00;
        emu_suspend = 1'b0;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        foreach (ra[k]) rchk("reset value", ra[k], 32'h0);
        bus(1'b1, 16'h7000, 32'hFFFF_FFFF);
        rchk("unmapped read", 16'h7000, 32'h0);
        bus(1'b1, UAG_IDX_SUSP, 32'hFF);
        rchk("suspend reserved bits", UAG_IDX_SUSP, 32'h18);
        // Letter A with alignment off, a wrong letter, then both letter cases.
        for (int k = 0; k < 4; k++) begin
            al = (k == 0) ? 32'h0 : 32'h2000;
            bus(1'b1, UAG_IDX_IMSK, {31'h0, k == 2});
            bus(1'b1, UAG_IDX_FGAP, al);
            node.send(ch[k]);
            repeat (10) @(posedge clk_sys);
            chk("irq", {31'h0, ab[k] & (k == 2)}, {31'h0, irq});
            rchk("done flag", UAG_IDX_FGAP, al | {16'h0, ab[k], 15'h0});
            bus(1'b1, UAG_IDX_FGAP, al);
            rchk("done after zero clear", UAG_IDX_FGAP, al | {16'h0, ab[k], 15'h0});
            rchk("event status", UAG_IDX_ISTS, {31'h0, ab[k]});
            bus(1'b1, UAG_IDX_ISTS, 32'h1);
            @(posedge clk_sys);
            chk("irq cleared", 32'h0, {31'h0, irq});
            bus(1'b1, UAG_IDX_FGAP, al | 32'h4000);
            rchk("done after clear", UAG_IDX_FGAP, al);
        end
        bus(1'b1, UAG_IDX_FGAP, 32'h7F00);
        rchk("control readback", UAG_IDX_FGAP, 32'h2000);
        pair(8'h55, 8'hAA, 40, 56);
        bus(1'b1, UAG_IDX_FGAP, 32'h20FF);
        rchk("gap readback", UAG_IDX_FGAP, 32'h20FF);
        pair(8'h01, 8'h80, 1016, 1032);
        bus(1'b1, UAG_IDX_FGAP, 32'h2000);
        bus(1'b1, UAG_IDX_SUSP, 32'h08);
        emu_suspend <= 1'b1;
        push(8'h3C, 2000, 1'b1);
        wait_rx(5);
        chk("run-on byte", 32'h3C, {24'h0, node.got_q[4]});
        bus(1'b1, UAG_IDX_SUSP, 32'h10);
        emu_suspend <= 1'b0;
        push(8'h5A, 2000, 1'b1);
        repeat (12) @(posedge clk_sys);
        emu_suspend <= 1'b1;
        push(8'hC3, 300, 1'b0);
        wait_rx(6);
        chk("graceful frame", 32'h5A, {24'h0, node.got_q[5]});
        bus(1'b1, UAG_IDX_SUSP, 32'h00);
        push(8'hC3, 300, 1'b0);
        emu_suspend <= 1'b0;
        push(8'hC3, 2000, 1'b1);
        wait_rx(7);
        chk("resumed byte", 32'hC3, {24'h0, node.got_q[6]});
        chk("stop bits", 32'h0, node.n_bad);
        // Low data bits are caught mid-frame, so a line that kept running would show the stop level.
        push(8'hF0, 2000, 1'b1);
        repeat (14) @(posedge clk_sys);
        emu_suspend <= 1'b1;
        repeat (4) @(posedge clk_sys);
        v = tx_pin;
        repeat (40) @(posedge clk_sys);
        chk("line low in data bits", 32'h0, {31'h0, v});
        chk("line frozen", {31'h0, v}, {31'h0, tx_pin});
        wrap_up();
    end
    initial begin
        repeat (100000) @(posedge clk_sys);
        timed_out("run");
    end
endmodule
